// >>> verilog/hc_topo_pkg.sv
// Shared constants of the host controller topology and control link
package hc_topo_pkg;

	// Downstream ports behind the internal hub
	localparam int NUM_PORTS = 3;
	localparam logic [3:0] HUB_PORTS = 4'h3;

	// Timing
	localparam int CLK_PERIOD_PS = 25000;
	localparam int HUB_ATTACH_NS = 2000;
	localparam int HUB_ATTACH_CYC = (HUB_ATTACH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_PULSE_NS = 500;
	localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Command codes on the control link
	localparam logic [2:0] OP_ROOT_STATUS = 3'h0;
	localparam logic [2:0] OP_ROOT_ENABLE = 3'h1;
	localparam logic [2:0] OP_SET_ADDR    = 3'h2;
	localparam logic [2:0] OP_HUB_INFO    = 3'h3;
	localparam logic [2:0] OP_PORT_STATUS = 3'h4;
	localparam logic [2:0] OP_EVENTS      = 3'h5;
	localparam logic [2:0] OP_SUSPEND     = 3'h6;
	localparam logic [2:0] OP_RESUME      = 3'h7;

	// Root port status bits
	localparam int ROOT_CONNECT_BIT = 0;
	localparam int ROOT_CHANGE_BIT  = 1;
	localparam int ROOT_ENABLED_BIT = 2;
	localparam int ROOT_HS_BIT      = 3;

	// Hub info bits, port count in [3:0]
	localparam int HUB_TT_BIT = 4;
	localparam int HUB_HS_BIT = 5;

	// Port status bits
	localparam int PORT_OC_BIT = 0;

	// Event flag bits
	localparam int EV_CONNECT_BIT = 0;
	localparam int EV_OC_BIT      = 1;
	localparam int EV_WAKE_BIT    = 2;
	localparam int EV_DMA_BIT     = 3;
	localparam int EV_WIDTH       = 4;

	// Values after reset, and the default address the host assigns to the hub
	localparam logic [7:0] RSP_RESET = 8'h00;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic [6:0] HUB_ADDR_DEFAULT = 7'h01;

	typedef enum logic [1:0] {
		DEV_ATTACH_WAIT,
		DEV_ATTACHED,
		DEV_ENABLED,
		DEV_CONFIGURED
	} dev_state_t;

	typedef enum logic [2:0] {
		H_RESET,
		H_POLL,
		H_ENABLE,
		H_ADDR,
		H_INFO,
		H_IDLE
	} host_state_t;

endpackage

// >>> verilog/hc_link_if.sv
// Link between the host controller and its processor and DMA side
`timescale 1ns/1ps
`default_nettype none
interface hc_link_if;
	import hc_topo_pkg::*;

	logic                 reset_low;
	logic                 cmd_valid;
	logic [2:0]           cmd_op;
	logic [7:0]           cmd_arg;
	logic                 rsp_valid;
	logic [7:0]           rsp_data;
	logic                 irq;
	logic                 dma_req_out;
	logic                 dma_ack_in_low;
	logic [NUM_PORTS-1:0] overcurrent_low;
	logic                 dev_susp_out;
	logic                 dev_susp_oe;
	logic                 host_wake_out;
	logic                 host_wake_oe;
	wire                  suspend_wake_pin;

	// Open-drain wire with external pull-up
	assign suspend_wake_pin = ((dev_susp_oe && !dev_susp_out) || (host_wake_oe && !host_wake_out))
		? 1'b0 : 1'b1;

	modport device (
		input  reset_low,
		input  cmd_valid,
		input  cmd_op,
		input  cmd_arg,
		output rsp_valid,
		output rsp_data,
		output irq,
		output dma_req_out,
		input  dma_ack_in_low,
		input  overcurrent_low,
		output dev_susp_out,
		output dev_susp_oe,
		input  suspend_wake_pin
	);

	modport host (
		output reset_low,
		output cmd_valid,
		output cmd_op,
		output cmd_arg,
		input  rsp_valid,
		input  rsp_data,
		input  irq,
		input  dma_req_out,
		output dma_ack_in_low,
		output overcurrent_low,
		output host_wake_out,
		output host_wake_oe,
		input  suspend_wake_pin
	);

endinterface
`default_nettype wire

// >>> verilog/hc_topo_device.sv
// Host controller end: root port, internal hub, suspend, DMA and interrupt pins
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1: Suspended releases pin, otherwise drives low
// RL2: Suspend output and wake input share pin
// RL3: Low reset input resets the controller
// RL4: Far side keeps inputs idle during reset
// RL5: DMA controller acknowledges; idle ack stays high
// RL6: Per-port active-low overcurrent inputs, sampled digitally
// RL7: Names ending low are asserted low
// RL8: One internal root port; hub serves all ports
// RL9: Hub is high-speed with speed translator
// RL10: Root port polled until hub connects
// RL11: Far side enables port, enumerates hub
// RL12: Enumerated hub never reports disconnect
// RL13: Enumerated hub reports exactly three ports
// RL14: DMA request raised whenever transfer needed, except while suspended
// RL15: Interrupt output signals controller events
// RL16: Low pin while suspended means wake-up
module hc_topo_device #(
	parameter int ATTACH_CYC = hc_topo_pkg::HUB_ATTACH_CYC
) (
	input  wire logic                             clk_sys,
	input  wire logic                             rst,
	input  wire logic                             ce,
	hc_link_if.device                             link,
	input  wire logic                             xfer_need,
	output logic                                  xfer_granted,
	output logic                                  suspended,
	output logic                                  hub_enumerated,
	output logic [hc_topo_pkg::NUM_PORTS-1:0]     overcurrent
);
	import hc_topo_pkg::*;

	localparam int CNT_W = $clog2(ATTACH_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ATTACH_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	dev_state_t           state;
	dev_state_t           next_state;
	logic [CNT_W-1:0]     attach_cnt;
	logic                 root_change;
	logic [6:0]           hub_addr;
	logic [EV_WIDTH-1:0]  events;
	logic [EV_WIDTH-1:0]  next_events;
	logic                 irq;
	logic                 dma_req;
	logic                 rsp_valid;
	logic [7:0]           rsp_data;
	logic [7:0]           next_rsp_data;
	logic [NUM_PORTS-1:0] oc_change;

	// Controller reset from system reset or the low-active pin
	wire dev_reset = rst | ~link.reset_low; // [RL3] [RL7]

	// Command decode
	wire op_root_status = link.cmd_valid && link.cmd_op == OP_ROOT_STATUS;
	wire op_root_enable = link.cmd_valid && link.cmd_op == OP_ROOT_ENABLE;
	wire op_set_addr    = link.cmd_valid && link.cmd_op == OP_SET_ADDR;
	wire op_events      = link.cmd_valid && link.cmd_op == OP_EVENTS;
	wire op_suspend     = link.cmd_valid && link.cmd_op == OP_SUSPEND;
	wire op_resume      = link.cmd_valid && link.cmd_op == OP_RESUME;
	wire port_in_range  = link.cmd_arg < 8'(NUM_PORTS);
	wire [1:0] port_sel = link.cmd_arg[1:0];

	// Topology status
	wire attach_done    = state == DEV_ATTACH_WAIT && attach_cnt == CNT_LAST;
	wire root_connected = state != DEV_ATTACH_WAIT; // [RL8] [RL12]
	wire root_enabled   = state == DEV_ENABLED || state == DEV_CONFIGURED;
	wire configured     = state == DEV_CONFIGURED;

	// Wake-up is the shared pin seen low while released
	wire wake_seen = suspended & ~link.suspend_wake_pin; // [RL2] [RL16]

	// DMA handshake; acknowledge is low-active
	wire dma_ack_seen = dma_req & ~link.dma_ack_in_low; // [RL5] [RL7]
	wire dma_start    = xfer_need & ~dma_req & ~suspended; // [RL14]

	// Event flags: a set in the reading cycle survives the clear
	wire [EV_WIDTH-1:0] ev_set = {dma_ack_seen, wake_seen, |oc_change, attach_done};
	assign next_events = (op_events ? {EV_WIDTH{1'b0}} : events) | ev_set;

	// Per-port overcurrent sampling
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_oc
			wire oc_now = ~link.overcurrent_low[gi]; // [RL6] [RL7]
			assign oc_change[gi] = oc_now ^ overcurrent[gi];
			always_ff @(posedge clk_sys) begin
				if (dev_reset) begin
					overcurrent[gi] <= 1'b0;
				end else if (ce) begin
					overcurrent[gi] <= oc_now; // [RL6]
				end
			end
		end
	endgenerate

	// Topology state: hub attaches once, then only moves forward
	always_comb begin
		next_state = state;
		case (state)
			DEV_ATTACH_WAIT: begin
				if (attach_done) begin
					next_state = DEV_ATTACHED; // [RL10]
				end
			end
			DEV_ATTACHED: begin
				if (op_root_enable) begin
					next_state = DEV_ENABLED; // [RL11]
				end
			end
			DEV_ENABLED: begin
				if (op_set_addr && link.cmd_arg[6:0] != ADDR_RESET) begin
					next_state = DEV_CONFIGURED;
				end
			end
			DEV_CONFIGURED: begin
				next_state = DEV_CONFIGURED; // [RL12]
			end
			default: begin
				next_state = DEV_ATTACH_WAIT;
			end
		endcase
	end

	// Answer selection
	always_comb begin
		next_rsp_data = RSP_RESET;
		case (link.cmd_op)
			OP_ROOT_STATUS: begin
				next_rsp_data[ROOT_CONNECT_BIT] = root_connected; // [RL10]
				next_rsp_data[ROOT_CHANGE_BIT]  = root_change;
				next_rsp_data[ROOT_ENABLED_BIT] = root_enabled;
				next_rsp_data[ROOT_HS_BIT]      = root_connected;
			end
			OP_HUB_INFO: begin
				if (configured) begin
					next_rsp_data[3:0]        = HUB_PORTS; // [RL13]
					next_rsp_data[HUB_TT_BIT] = 1'b1; // [RL9]
					next_rsp_data[HUB_HS_BIT] = 1'b1; // [RL9]
				end
			end
			OP_PORT_STATUS: begin
				if (port_in_range) begin
					next_rsp_data[PORT_OC_BIT] = overcurrent[port_sel];
				end
			end
			OP_EVENTS: begin
				next_rsp_data[EV_WIDTH-1:0] = events;
			end
			OP_SET_ADDR: begin
				next_rsp_data[6:0] = link.cmd_arg[6:0];
			end
			default: begin
				next_rsp_data = RSP_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (dev_reset) begin
			state      <= DEV_ATTACH_WAIT;
			attach_cnt <= CNT_ZERO;
		end else if (ce) begin
			state <= next_state;
			if (state == DEV_ATTACH_WAIT && !attach_done) begin
				attach_cnt <= attach_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dev_reset) begin
			root_change <= 1'b0;
			hub_addr    <= ADDR_RESET;
		end else if (ce) begin
			if (attach_done) begin
				root_change <= 1'b1; // [RL10]
			end else if (op_root_status) begin
				root_change <= 1'b0;
			end
			if (op_set_addr && state == DEV_ENABLED) begin
				hub_addr <= link.cmd_arg[6:0];
			end
		end
	end

	// Suspend entry only after enumeration; pin low or command resumes
	always_ff @(posedge clk_sys) begin
		if (dev_reset) begin
			suspended <= 1'b0;
		end else if (ce) begin
			if (wake_seen || op_resume) begin
				suspended <= 1'b0; // [RL16]
			end else if (op_suspend && configured) begin
				suspended <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dev_reset) begin
			events <= '0;
			irq    <= 1'b0;
		end else if (ce) begin
			events <= next_events;
			irq    <= |next_events; // [RL15]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dev_reset) begin
			dma_req      <= 1'b0;
			xfer_granted <= 1'b0;
		end else if (ce) begin
			xfer_granted <= dma_ack_seen;
			if (dma_ack_seen) begin
				dma_req <= 1'b0;
			end else if (dma_start) begin
				dma_req <= 1'b1; // [RL14]
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dev_reset) begin
			rsp_valid <= 1'b0;
			rsp_data  <= RSP_RESET;
		end else if (ce) begin
			rsp_valid <= link.cmd_valid;
			if (link.cmd_valid) begin
				rsp_data <= next_rsp_data;
			end
		end
	end

	assign hub_enumerated   = configured & (hub_addr != ADDR_RESET);
	assign link.rsp_valid   = rsp_valid;
	assign link.rsp_data    = rsp_data;
	assign link.irq         = irq;
	assign link.dma_req_out = dma_req;
	// Open drain: drive low when awake, release when suspended
	assign link.dev_susp_out = 1'b0; // [RL1]
	assign link.dev_susp_oe  = ~suspended; // [RL1] [RL2]

endmodule
`default_nettype wire

// >>> verilog/hc_topo_host.sv
// Processor and DMA end: bring-up, enumeration, events, DMA acknowledge, wake
`timescale 1ns/1ps
`default_nettype none
module hc_topo_host #(
	parameter logic [6:0] HUB_ADDR = hc_topo_pkg::HUB_ADDR_DEFAULT,
	parameter int         WAKE_CYC = hc_topo_pkg::WAKE_PULSE_CYC
) (
	input  wire logic                             clk_sys,
	input  wire logic                             rst,
	input  wire logic                             ce,
	hc_link_if.host                               link,
	input  wire logic                             ctrl_reset,
	input  wire logic                             suspend_req,
	input  wire logic                             wake_req,
	input  wire logic                             dma_enable,
	input  wire logic [hc_topo_pkg::NUM_PORTS-1:0] board_overcurrent_low,
	output logic                                  enumerated,
	output logic [3:0]                            hub_port_count,
	output logic                                  hub_has_tt,
	output logic [hc_topo_pkg::EV_WIDTH-1:0]      event_flags
);
	import hc_topo_pkg::*;

	localparam int WK_W = $clog2(WAKE_CYC + 1);
	localparam logic [WK_W-1:0] WK_LOAD = WK_W'(WAKE_CYC);
	localparam logic [WK_W-1:0] WK_ZERO = '0;

	host_state_t          state;
	logic                 busy;
	logic                 cmd_valid;
	logic [2:0]           cmd_op;
	logic [7:0]           cmd_arg;
	logic                 reset_low;
	logic                 ack_low;
	logic [NUM_PORTS-1:0] oc_low;
	logic                 susp_pend;
	logic [WK_W-1:0]      wake_cnt;

	wire rsp      = busy & link.rsp_valid;
	wire can_issue = ~busy & ~cmd_valid & state != H_RESET;
	wire connect  = link.rsp_data[ROOT_CONNECT_BIT];

	// Idle-time command choice
	wire idle_ev   = state == H_IDLE && link.irq;
	wire idle_susp = state == H_IDLE && !link.irq && susp_pend;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reset_low <= 1'b0;
			oc_low    <= '1;
			ack_low   <= 1'b1;
		end else if (ce) begin
			reset_low <= ~ctrl_reset; // [RL3] [RL7]
			oc_low    <= ctrl_reset ? '1 : board_overcurrent_low; // [RL4] [RL6]
			// One-cycle low acknowledge per request; high when unused
			ack_low   <= ~(dma_enable & link.dma_req_out & ack_low & ~ctrl_reset); // [RL5]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || ctrl_reset) begin
			state     <= H_RESET;
			busy      <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_op    <= OP_ROOT_STATUS;
			cmd_arg   <= 8'h00;
		end else if (ce) begin
			cmd_valid <= 1'b0;
			if (link.rsp_valid) begin
				busy <= 1'b0;
			end
			if (can_issue) begin
				case (state)
					H_POLL: cmd_op <= OP_ROOT_STATUS; // [RL10]
					H_ENABLE: cmd_op <= OP_ROOT_ENABLE; // [RL11]
					H_ADDR: cmd_op <= OP_SET_ADDR; // [RL11]
					H_INFO: cmd_op <= OP_HUB_INFO;
					default: cmd_op <= idle_ev ? OP_EVENTS : OP_SUSPEND;
				endcase
				cmd_arg   <= {1'b0, HUB_ADDR};
				cmd_valid <= state != H_IDLE || idle_ev || idle_susp;
				busy      <= state != H_IDLE || idle_ev || idle_susp;
			end
			case (state)
				H_RESET: state <= H_POLL;
				H_POLL: if (rsp && connect) state <= H_ENABLE; // [RL10]
				H_ENABLE: if (rsp) state <= H_ADDR;
				H_ADDR: if (rsp) state <= H_INFO;
				H_INFO: if (rsp) state <= H_IDLE; // [RL12]
				H_IDLE: state <= H_IDLE;
				default: state <= H_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || ctrl_reset) begin
			enumerated     <= 1'b0;
			hub_port_count <= 4'h0;
			hub_has_tt     <= 1'b0;
			event_flags    <= '0;
			susp_pend      <= 1'b0;
			wake_cnt       <= WK_ZERO;
		end else if (ce) begin
			if (state == H_INFO && rsp) begin
				enumerated     <= 1'b1;
				hub_port_count <= link.rsp_data[3:0];
				hub_has_tt     <= link.rsp_data[HUB_TT_BIT];
			end
			if (state == H_IDLE && rsp && cmd_op == OP_EVENTS) begin
				event_flags <= link.rsp_data[EV_WIDTH-1:0];
			end
			if (suspend_req) begin
				susp_pend <= 1'b1;
			end else if (can_issue && idle_susp) begin
				susp_pend <= 1'b0;
			end
			if (wake_req && wake_cnt == WK_ZERO) begin
				wake_cnt <= WK_LOAD; // [RL16]
			end else if (wake_cnt != WK_ZERO) begin
				wake_cnt <= wake_cnt - 1'b1;
			end
		end
	end

	assign link.reset_low       = reset_low;
	assign link.cmd_valid       = cmd_valid;
	assign link.cmd_op          = cmd_op;
	assign link.cmd_arg         = cmd_arg;
	assign link.dma_ack_in_low  = ack_low;
	assign link.overcurrent_low = oc_low;
	assign link.host_wake_out   = 1'b0;
	assign link.host_wake_oe    = wake_cnt != WK_ZERO; // [RL2]

endmodule
`default_nettype wire

// >>> dv/hc_topo_assertions.sv
// Concurrent checks on the link between host controller and processor side
`timescale 1ns/1ps
`default_nettype none
module hc_topo_assertions
	import hc_topo_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       reset_low,
	input wire logic       cmd_valid,
	input wire logic [2:0] cmd_op,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic       irq,
	input wire logic       dma_req_out,
	input wire logic       dma_ack_in_low,
	input wire logic       dev_susp_out,
	input wire logic       dev_susp_oe,
	input wire logic       suspend_wake_pin
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	rsp_follows_cmd_a: assert property (cmd_valid && reset_low ##1 reset_low |-> rsp_valid)
		else $error("command not answered on next cycle");
	rsp_needs_cmd_a: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("answer without a command");
	hub_info_a: assert property (cmd_valid && cmd_op == OP_HUB_INFO && reset_low ##1
		rsp_valid && rsp_data != RSP_RESET |-> rsp_data[3:0] == HUB_PORTS
		&& rsp_data[HUB_TT_BIT] && rsp_data[HUB_HS_BIT])
		else $error("hub info wrong");
	susp_drive_low_a: assert property (dev_susp_oe |-> !dev_susp_out && !suspend_wake_pin)
		else $error("suspend pin not low while driven");
	reset_quiet_a: assert property (!reset_low |=> dev_susp_oe && !rsp_valid && !irq
		&& !dma_req_out)
		else $error("outputs active after low reset input");
	wake_exit_a: assert property (!dev_susp_oe && !suspend_wake_pin ##1 reset_low
		|-> dev_susp_oe)
		else $error("low pin while suspended did not wake");
	susp_no_dma_a: assert property (!dev_susp_oe && $past(!dev_susp_oe)
		|-> !$rose(dma_req_out))
		else $error("dma request raised while suspended");
	dma_ack_drop_a: assert property (dma_req_out && !dma_ack_in_low ##1 reset_low
		|-> !dma_req_out)
		else $error("dma request kept after acknowledge");
	dma_hold_a: assert property (dma_req_out && dma_ack_in_low && reset_low
		|=> dma_req_out)
		else $error("dma request dropped without acknowledge");

	cover property (cmd_valid && cmd_op == OP_HUB_INFO ##1 rsp_valid);
	cover property (dma_req_out && !dma_ack_in_low);
	cover property (!dev_susp_oe && !suspend_wake_pin);
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench joining both ends of the host controller link
`timescale 1ns/1ps
`default_nettype none
module tb;
	import hc_topo_pkg::*;

	localparam int ATTACH = 8;
	localparam int WAKE   = 4;
	localparam int LIMIT  = 20000;

	logic                 clk_sys;
	logic                 rst;
	logic                 ce;
	logic                 xfer_need;
	logic                 xfer_granted;
	logic                 suspended;
	logic                 hub_enumerated;
	logic [NUM_PORTS-1:0] overcurrent;
	logic                 ctrl_reset;
	logic                 suspend_req;
	logic                 wake_req;
	logic                 dma_enable;
	logic [NUM_PORTS-1:0] board_oc_low;
	logic                 enumerated;
	logic [3:0]           hub_port_count;
	logic                 hub_has_tt;
	logic [EV_WIDTH-1:0]  event_flags;
	int                   n_errors;
	int                   num_checks;
	int                   cycles;
	int                   i;
	int                   grants;

	hc_link_if u_hc_link_if ();

	hc_topo_device #(.ATTACH_CYC(ATTACH)) u_hc_topo_device (
		.clk_sys(clk_sys), .rst(rst), .ce(ce), .link(u_hc_link_if.device),
		.xfer_need(xfer_need), .xfer_granted(xfer_granted), .suspended(suspended),
		.hub_enumerated(hub_enumerated), .overcurrent(overcurrent));

	hc_topo_host #(.WAKE_CYC(WAKE)) u_hc_topo_host (
		.clk_sys(clk_sys), .rst(rst), .ce(ce), .link(u_hc_link_if.host),
		.ctrl_reset(ctrl_reset), .suspend_req(suspend_req), .wake_req(wake_req),
		.dma_enable(dma_enable), .board_overcurrent_low(board_oc_low),
		.enumerated(enumerated), .hub_port_count(hub_port_count),
		.hub_has_tt(hub_has_tt), .event_flags(event_flags));

	hc_topo_assertions u_hc_topo_assertions (
		.clk_sys(clk_sys), .rst(rst), .reset_low(u_hc_link_if.reset_low),
		.cmd_valid(u_hc_link_if.cmd_valid), .cmd_op(u_hc_link_if.cmd_op),
		.rsp_valid(u_hc_link_if.rsp_valid), .rsp_data(u_hc_link_if.rsp_data),
		.irq(u_hc_link_if.irq), .dma_req_out(u_hc_link_if.dma_req_out),
		.dma_ack_in_low(u_hc_link_if.dma_ack_in_low),
		.dev_susp_out(u_hc_link_if.dev_susp_out), .dev_susp_oe(u_hc_link_if.dev_susp_oe),
		.suspend_wake_pin(u_hc_link_if.suspend_wake_pin));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic complete_run();
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check1(input logic got, input logic exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %b", $time, msg, got);
		end
	endtask

	task automatic check4(input logic [3:0] got, input logic [3:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	// Sample away from the driving edge
	task automatic settle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic wait_enum();
		for (i = 0; i < 400 && enumerated !== 1'b1; i++) settle(1);
		check1(enumerated, 1'b1, "host enumerated");
		check1(hub_enumerated, 1'b1, "hub enumerated");
		check4(hub_port_count, HUB_PORTS, "hub port count");
		check1(hub_has_tt, 1'b1, "speed translator");
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles >= LIMIT) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		n_errors = 0;
		num_checks = 0;
		cycles = 0;
		grants = 0;
		rst = 1'b1;
		ce = 1'b1;
		xfer_need = 1'b0;
		ctrl_reset = 1'b0;
		suspend_req = 1'b0;
		wake_req = 1'b0;
		dma_enable = 1'b1;
		board_oc_low = '1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		settle(1);
		check1(u_hc_link_if.suspend_wake_pin, 1'b0, "pin low when awake");
		wait_enum();
		// Hub must stay attached once enumerated
		for (i = 0; i < 50; i++) begin
			settle(1);
			check1(hub_enumerated, 1'b1, "hub still attached");
		end
		// One port at a time in overcurrent, active low
		for (int p = 0; p < NUM_PORTS; p++) begin
			@(posedge clk_sys) board_oc_low <= ~(3'h1 << p);
			settle(6);
			check4({1'b0, overcurrent}, {1'b0, 3'h1 << p}, "overcurrent port");
			check4(event_flags, 4'h1 << EV_OC_BIT, "overcurrent event");
			@(posedge clk_sys) board_oc_low <= '1;
			settle(6);
			check4({1'b0, overcurrent}, 4'h0, "overcurrent cleared");
			check4(event_flags, 4'h1 << EV_OC_BIT, "overcurrent gone event");
		end
		// Acknowledged transfer
		@(posedge clk_sys) xfer_need <= 1'b1;
		for (i = 0; i < 20 && xfer_granted !== 1'b1; i++) settle(1);
		check1(xfer_granted, 1'b1, "transfer granted");
		@(posedge clk_sys) xfer_need <= 1'b0;
		// Unacknowledged request must stand
		dma_enable <= 1'b0;
		settle(4);
		@(posedge clk_sys) xfer_need <= 1'b1;
		for (i = 0; i < 30; i++) begin
			settle(1);
			if (xfer_granted === 1'b1) grants++;
		end
		check1(u_hc_link_if.dma_req_out, 1'b1, "request standing");
		check4(grants[3:0], 4'h0, "no grant without ack");
		@(posedge clk_sys) dma_enable <= 1'b1;
		for (i = 0; i < 20 && xfer_granted !== 1'b1; i++) settle(1);
		check1(xfer_granted, 1'b1, "late grant");
		@(posedge clk_sys) xfer_need <= 1'b0;
		settle(4);
		// Suspend, refused dma, then wake through the pin
		@(posedge clk_sys) suspend_req <= 1'b1;
		@(posedge clk_sys) suspend_req <= 1'b0;
		for (i = 0; i < 60 && suspended !== 1'b1; i++) settle(1);
		check1(suspended, 1'b1, "suspended");
		check1(u_hc_link_if.suspend_wake_pin, 1'b1, "pin released");
		@(posedge clk_sys) xfer_need <= 1'b1;
		settle(6);
		check1(u_hc_link_if.dma_req_out, 1'b0, "no request suspended");
		@(posedge clk_sys) wake_req <= 1'b1;
		@(posedge clk_sys) wake_req <= 1'b0;
		for (i = 0; i < 20 && suspended !== 1'b0; i++) settle(1);
		check1(suspended, 1'b0, "woken by pin");
		check1(u_hc_link_if.dev_susp_oe, 1'b1, "pin driven again");
		for (i = 0; i < 20 && xfer_granted !== 1'b1; i++) settle(1);
		check1(xfer_granted, 1'b1, "grant after wake");
		@(posedge clk_sys) xfer_need <= 1'b0;
		settle(4);
		// Clock enable low freezes both ends with the link idle
		settle(6);
		@(posedge clk_sys) ce <= 1'b0;
		xfer_need <= 1'b1;
		settle(6);
		check1(u_hc_link_if.dma_req_out, 1'b0, "request frozen");
		@(posedge clk_sys) ce <= 1'b1;
		for (i = 0; i < 20 && xfer_granted !== 1'b1; i++) settle(1);
		check1(xfer_granted, 1'b1, "grant after freeze");
		@(posedge clk_sys) xfer_need <= 1'b0;
		settle(8);
		// Low reset input in mid-run, then full bring-up again
		@(posedge clk_sys) ctrl_reset <= 1'b1;
		settle(4);
		check1(hub_enumerated, 1'b0, "hub reset");
		check1(u_hc_link_if.irq, 1'b0, "irq reset");
		check1(u_hc_link_if.dma_ack_in_low, 1'b1, "ack idle in reset");
		@(posedge clk_sys) ctrl_reset <= 1'b0;
		settle(2);
		wait_enum();
		complete_run();
	end
endmodule
`default_nettype wire
